// *** hdl/bxa_regs.svh ***
// Constants for the byte ALU: opcode codes, destination codes and bit fields.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef BXA_REGS_SVH
`define BXA_REGS_SVH

// ---------------------------------------------------------------
// Operation codes
// ---------------------------------------------------------------
`define BXA_OP_NONE 3'h0
`define BXA_OP_SUB 3'h1
`define BXA_OP_XORF 3'h2
`define BXA_OP_SWAP 3'h3
`define BXA_OP_XORL 3'h4

// ---------------------------------------------------------------
// Destination select and field layout
// ---------------------------------------------------------------
`define BXA_DEST_ACC 1'h0
`define BXA_DEST_FILE 1'h1
`define BXA_ADDR_MAX 7'h7f
`define BXA_LO_MSB 3
`define BXA_HI_LSB 4
`define BXA_BYTE_MSB 7
`define BXA_ACC_RESET 8'h00
`define BXA_ZERO_BYTE 8'h00
`define BXA_FLAG_RESET 1'h0
`define BXA_ADDR_RESET 7'h00
`define BXA_BORROW_BIT 8
`define BXA_NIB_BORROW_BIT 4

`endif

// *** hdl/bxa_pkg.sv ***
// Types shared by the byte ALU modules.
// Assumes bxa_regs.svh is compiled alongside.
package bxa_pkg;
   // Operation selector
   typedef enum logic [2:0] {
      BXA_NONE = 3'h0,
      BXA_SUB = 3'h1,
      BXA_XORF = 3'h2,
      BXA_SWAP = 3'h3,
      BXA_XORL = 3'h4
   } bxa_op_t;
endpackage : bxa_pkg

// *** hdl/bxa_core_if.sv ***
// Interface carrying operands and results between top and the ALU core.
// Assumes a single clock domain; purely combinational links.
`timescale 1ns/10ps
interface bxa_core_if;
   bxa_pkg::bxa_op_t op;
   logic [7:0] acc;
   logic [7:0] operand;
   logic [7:0] result;
   logic carry;
   logic digitCarry;
   logic updCarry;
   logic updZero;
   modport top (output op, output acc, output operand,
      input result, input carry, input digitCarry, input updCarry,
      input updZero);
   modport core (input op, input acc, input operand,
      output result, output carry, output digitCarry, output updCarry,
      output updZero);
endinterface : bxa_core_if

// *** hdl/bxa_alu_core.sv ***
// Combinational result and flag logic of the byte ALU.
// Assumes operands are stable for the cycle; no state of its own.
`timescale 1ns/10ps
`include "bxa_regs.svh"
module bxa_alu_core (
   // Operands and results
   bxa_core_if.core alu
);
   logic [8:0] diff;
   logic [4:0] diffLo;

   // ---------------------------------------------------------------
   // Result and flags
   // ---------------------------------------------------------------
   // Extra bit of the difference is the inverted borrow
   always_comb begin
      diff = {1'b0, alu.operand} + {1'b0, ~alu.acc} + 9'h001;
      diffLo = {1'b0, alu.operand[`BXA_LO_MSB:0]}
         + {1'b0, ~alu.acc[`BXA_LO_MSB:0]} + 5'h01;
      alu.result = `BXA_ZERO_BYTE;
      alu.carry = diff[`BXA_BORROW_BIT];
      alu.digitCarry = diffLo[`BXA_NIB_BORROW_BIT];
      alu.updCarry = 1'b0;
      alu.updZero = 1'b0;
      unique case (alu.op)
         bxa_pkg::BXA_NONE: begin
         end
         bxa_pkg::BXA_SUB: begin
            alu.result = diff[`BXA_BYTE_MSB:0];
            alu.updCarry = 1'b1;
            alu.updZero = 1'b1;
         end
         bxa_pkg::BXA_XORF: begin
            alu.result = alu.acc ^ alu.operand;
            alu.updZero = 1'b1;
         end
         bxa_pkg::BXA_SWAP: begin
            alu.result = {alu.operand[`BXA_LO_MSB:0],
               alu.operand[`BXA_BYTE_MSB:`BXA_HI_LSB]};
         end
         bxa_pkg::BXA_XORL: begin
            alu.result = alu.acc ^ alu.operand;
            alu.updZero = 1'b1;
         end
         default: begin
         end
      endcase
   end
endmodule : bxa_alu_core

// *** hdl/bxa_alu.sv ***
// Byte ALU for subtract, XOR with file or literal, and nibble swap.
// Assumes the file register value arrives with the request each cycle.
`timescale 1ns/10ps
`include "bxa_regs.svh"
module bxa_alu (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Request
   input wire logic opValid,
   input wire logic [2:0] opCode,
   input wire logic destSel,
   input wire logic [6:0] fileAddr,
   input wire logic [7:0] operand,
   // Accumulator and write-back
   output logic [7:0] acc,
   output logic fileWrEn,
   output logic [6:0] fileWrAddr,
   output logic [7:0] fileWrData,
   // Status flags
   output logic carryFlag,
   output logic digit_carry_flag,
   output logic zeroFlag
);
   logic rstSync1;
   logic rstSync;
   logic [7:0] next_acc;
   logic next_fileWrEn;
   logic [6:0] next_fileWrAddr;
   logic [7:0] next_fileWrData;
   logic next_carryFlag;
   logic next_digit_carry_flag;
   logic next_zeroFlag;
   logic toFile;

   bxa_core_if alu ();

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   // Two stages so the release is clean against ref_clk
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1 <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync <= rstSync1;
      end
   end

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   // Unknown codes fall back to no operation
   always_comb begin
      alu.acc = acc;
      alu.operand = operand;
      alu.op = bxa_pkg::BXA_NONE;
      if (opValid) begin
         unique case (opCode)
            `BXA_OP_SUB: alu.op = bxa_pkg::BXA_SUB;
            `BXA_OP_XORF: alu.op = bxa_pkg::BXA_XORF;
            `BXA_OP_SWAP: alu.op = bxa_pkg::BXA_SWAP;
            `BXA_OP_XORL: alu.op = bxa_pkg::BXA_XORL;
            default: alu.op = bxa_pkg::BXA_NONE;
         endcase
      end
   end

   bxa_alu_core u_core (
      .alu(alu)
   );

   // Literal XOR ignores the destination bit
   always_comb begin
      toFile = (destSel == `BXA_DEST_FILE)
         && (alu.op != bxa_pkg::BXA_XORL)
         && (alu.op != bxa_pkg::BXA_NONE);
      next_acc = acc;
      next_fileWrEn = toFile;
      next_fileWrAddr = fileAddr & `BXA_ADDR_MAX;
      next_fileWrData = alu.result;
      next_carryFlag = carryFlag;
      next_digit_carry_flag = digit_carry_flag;
      next_zeroFlag = zeroFlag;
      if (alu.op != bxa_pkg::BXA_NONE && !toFile) begin
         next_acc = alu.result;
      end
      if (alu.updCarry) begin
         next_carryFlag = alu.carry;
         next_digit_carry_flag = alu.digitCarry;
      end
      if (alu.updZero) begin
         next_zeroFlag = (alu.result == `BXA_ZERO_BYTE);
      end
   end

   // Register all outputs
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         acc <= `BXA_ACC_RESET;
         fileWrEn <= 1'b0;
         fileWrAddr <= `BXA_ADDR_RESET;
         fileWrData <= `BXA_ZERO_BYTE;
         carryFlag <= `BXA_FLAG_RESET;
         digit_carry_flag <= `BXA_FLAG_RESET;
         zeroFlag <= `BXA_FLAG_RESET;
      end else begin
         acc <= next_acc;
         fileWrEn <= next_fileWrEn;
         fileWrAddr <= next_fileWrAddr;
         fileWrData <= next_fileWrData;
         carryFlag <= next_carryFlag;
         digit_carry_flag <= next_digit_carry_flag;
         zeroFlag <= next_zeroFlag;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Subtract: operands are taken at the request edge, so every
   // expectation reads them back through $past one edge later
   a_sub_result: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_SUB && !destSel
      |=> acc == $past(operand) - $past(acc))
      else $error("subtract result wrong");
   a_sub_file: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_SUB && destSel
      |=> fileWrEn && fileWrData == $past(operand) - $past(acc)
      && $stable(acc))
      else $error("subtract to file wrong");
   a_sub_carry: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_SUB
      |=> carryFlag == ($past(acc) <= $past(operand)))
      else $error("subtract carry wrong");
   a_sub_digit: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_SUB |=> digit_carry_flag ==
      ($past(acc[`BXA_LO_MSB:0]) <= $past(operand[`BXA_LO_MSB:0])))
      else $error("subtract digit carry wrong");

   // Xor with a file register: destination chosen, carry flags kept
   a_xorf_dest: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_XORF && destSel
      |=> fileWrEn && fileWrData == ($past(acc) ^ $past(operand))
      && $stable(acc) && $stable(carryFlag))
      else $error("file xor routing wrong");
   a_xorf_acc: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_XORF && !destSel
      |=> !fileWrEn && acc == ($past(acc) ^ $past(operand))
      && $stable(carryFlag) && $stable(digit_carry_flag))
      else $error("accumulator xor wrong");
   // Literal xor lands in the accumulator whatever the destination bit
   a_xorl_acc: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_XORL
      |=> !fileWrEn && acc == ($past(acc) ^ $past(operand)))
      else $error("literal xor wrong");
   a_xorl_flags: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_XORL
      |=> $stable(carryFlag) && $stable(digit_carry_flag))
      else $error("literal xor touched carry");

   // Swap moves nibbles only; no flag may follow its result
   a_swap_flags: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_SWAP && !destSel
      |=> acc == {$past(operand[`BXA_LO_MSB:0]),
      $past(operand[`BXA_BYTE_MSB:`BXA_HI_LSB])}
      && $stable(zeroFlag) && $stable(carryFlag))
      else $error("swap wrong");
   a_swap_file: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && opCode == `BXA_OP_SWAP && destSel
      |=> fileWrEn && fileWrData == {$past(operand[`BXA_LO_MSB:0]),
      $past(operand[`BXA_BYTE_MSB:`BXA_HI_LSB])} && $stable(acc)
      && $stable(zeroFlag) && $stable(carryFlag)
      && $stable(digit_carry_flag))
      else $error("swap to file wrong");

   // Zero flag follows the 8-bit result in either destination
   a_zero_flag: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      fileWrEn && $past(opCode) == `BXA_OP_XORF
      |-> zeroFlag == (fileWrData == `BXA_ZERO_BYTE))
      else $error("zero flag wrong");
   a_zero_sub: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      fileWrEn && $past(opCode) == `BXA_OP_SUB
      |-> zeroFlag == (fileWrData == `BXA_ZERO_BYTE))
      else $error("zero flag after file subtract wrong");
   a_zero_acc: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && (opCode == `BXA_OP_SUB || opCode == `BXA_OP_XORF
      || opCode == `BXA_OP_XORL)
      && (!destSel || opCode == `BXA_OP_XORL)
      |=> zeroFlag == (acc == `BXA_ZERO_BYTE))
      else $error("zero flag after accumulator write wrong");

   // Idle or unknown requests leave the accumulator and flags standing and drop fileWrEn; the write
   // address and data only matter when a write is actually issued
   a_idle_hold: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      !opValid |=> !fileWrEn && $stable(acc))
      else $error("idle changed state");
   a_bad_code: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && (opCode == `BXA_OP_NONE || opCode > `BXA_OP_XORL)
      |=> !fileWrEn && $stable(acc) && $stable(zeroFlag)
      && $stable(carryFlag) && $stable(digit_carry_flag))
      else $error("unknown code changed state");
   a_file_addr: assert property (@(posedge ref_clk)
      disable iff (!rstSync)
      opValid && destSel && (opCode == `BXA_OP_SUB
      || opCode == `BXA_OP_XORF || opCode == `BXA_OP_SWAP)
      |=> fileWrEn && fileWrAddr == $past(fileAddr))
      else $error("file write address wrong");
endmodule : bxa_alu

// *** tb/bxa_alu_test.sv ***
// Self-checking bench for the byte ALU top module.
// Assumes bxa_pkg, the core interface and both design modules compile first.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module bxa_alu_test;
   // ---------------------------------------------------------------
   // Signals and expected state
   // ---------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic opValid = 1'b0;
   logic [2:0] opCode = 3'h0;
   logic destSel = 1'h0;
   logic [6:0] fileAddr = 7'h00;
   logic [7:0] operand = 8'h00;
   logic [7:0] acc, fileWrData;
   logic [6:0] fileWrAddr;
   logic fileWrEn, carryFlag, digit_carry_flag, zeroFlag;
   int errors = 0;
   int checked = 0;
   logic [7:0] eAcc = 8'h00;
   logic eC = 1'h0, eDc = 1'h0, eZ = 1'h0;

   bxa_alu uut (.ref_clk(ref_clk), .rst_n(rst_n), .opValid(opValid),
      .opCode(opCode), .destSel(destSel), .fileAddr(fileAddr),
      .operand(operand), .acc(acc), .fileWrEn(fileWrEn),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
      .carryFlag(carryFlag), .digit_carry_flag(digit_carry_flag),
      .zeroFlag(zeroFlag));

   // 25 MHz clock
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   // Verdict and end of run, shared with the watchdog
   task finish_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // Reset held three edges; first request lands on the third edge after
   task reset_seq;
      opValid = 1'b0;
      rst_n = 1'b0;
      {eAcc, eC, eDc, eZ} = 11'h000;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK({acc, fileWrEn, fileWrAddr, fileWrData}, 24'h000000)
      `CHK({carryFlag, digit_carry_flag, zeroFlag}, 3'h0)
      rst_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : reset_seq

   // One request; inputs are left standing so calls run back to back
   task run(input logic v, input logic [2:0] op, input logic d,
      input logic [6:0] a, input logic [7:0] f);
      logic [7:0] r;
      logic wr;
      logic ok;
      ok = v && op >= 3'h1 && op <= 3'h4;
      r = (op == 3'h3) ? {f[3:0], f[7:4]} : (op == 3'h1) ? f - eAcc : f ^ eAcc;
      if (ok && op == 3'h1) begin
         eC = eAcc <= f;
         eDc = eAcc[3:0] <= f[3:0];
      end
      if (ok && op != 3'h3) eZ = (r == 8'h00);
      wr = ok && d && op != 3'h4;
      if (ok && !wr) eAcc = r;
      opValid = v;
      opCode = op;
      destSel = d;
      fileAddr = a;
      operand = f;
      @(posedge ref_clk);
      #1;
      `CHK(acc, eAcc)
      `CHK(fileWrEn, wr)
      if (wr) begin
         `CHK(fileWrAddr, a)
         `CHK(fileWrData, r)
      end
      `CHK(carryFlag, eC)
      `CHK(digit_carry_flag, eDc)
      `CHK(zeroFlag, eZ)
   endtask : run

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Subtract across borrow, nibble borrow, equality and both ends
   task t_sub;
      logic [7:0] w [6] = '{8'h03, 8'h05, 8'h28, 8'h77, 8'h00, 8'hff};
      logic [7:0] f [6] = '{8'h05, 8'h03, 8'h23, 8'h77, 8'hff, 8'h00};
      for (int i = 0; i < 6; i++) begin
         run(1'b1, 3'h4, 1'b0, 7'h00, eAcc ^ w[i]);
         run(1'b1, 3'h1, i[0], i[0] ? 7'h7f : 7'h00, f[i]);
      end
   endtask : t_sub

   // File and literal xor, zero results, literal ignores destination
   task t_xor;
      run(1'b1, 3'h4, 1'b0, 7'h00, eAcc ^ 8'h5a);
      run(1'b1, 3'h2, 1'b1, 7'h11, 8'h5a);
      run(1'b1, 3'h2, 1'b0, 7'h22, 8'h0f);
      run(1'b1, 3'h4, 1'b1, 7'h33, 8'h55);
   endtask : t_xor

   // Swap after a borrowing subtract: a zero result or a fresh carry
   // would show if swap leaked into the flags
   task t_swap;
      run(1'b1, 3'h4, 1'b0, 7'h00, eAcc ^ 8'hff);
      run(1'b1, 3'h1, 1'b1, 7'h01, 8'h10);
      run(1'b1, 3'h3, 1'b0, 7'h02, 8'h00);
      run(1'b1, 3'h3, 1'b1, 7'h7f, 8'ha5);
   endtask : t_swap

   // Idle and unknown codes leave the accumulator and flags alone and write nothing
   task t_refuse;
      run(1'b0, 3'h1, 1'b1, 7'h05, 8'h99);
      run(1'b1, 3'h0, 1'b1, 7'h05, 8'h99);
      run(1'b1, 3'h5, 1'b0, 7'h05, 8'h99);
      run(1'b1, 3'h7, 1'b1, 7'h05, 8'h99);
   endtask : t_refuse

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      reset_seq();
      t_sub();
      t_xor();
      t_swap();
      t_refuse();
      reset_seq();
      t_swap();
      finish_test();
   end

   // Far beyond the few dozen cycles the tests need
   initial begin
      #(4000 * 40);
      errors++;
      finish_test();
   end
endmodule : bxa_alu_test
